// *** design/ext_req_edge.sv ***
module ext_req_edge (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    input  wire logic i_rising,
    input  wire logic i_clear,
    output logic      o_level,
    output logic      o_pending
);

    logic [2:0] sync;
    logic       prev;
    logic       stable;
    logic       edge_hit;

    // Level counts once stages two and three agree
    assign stable   = (sync[1] == sync[2]);
    assign edge_hit = stable && (sync[2] != prev) && (sync[2] == i_rising);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync      <= 3'h0;
            prev      <= 1'b0;
            o_pending <= 1'b0;
            o_level   <= 1'b0;
        end
        else
        begin
            sync <= {sync[1:0], i_pin};
            if (stable)
            begin
                prev    <= sync[2];
                o_level <= sync[2];
            end
            // Set wins over clear so no edge is lost
            o_pending <= edge_hit | (o_pending & ~i_clear);
        end
    end

endmodule

// *** design/prio_irq_pkg.sv ***
package prio_irq_pkg;

    localparam int          VEC_W          = 8;
    localparam int          PRIO_W         = 2;
    localparam int          PRIO_DEPTH     = 4;
    localparam int          NUM_EXT        = 2;

    localparam logic [7:0]  INT_BASE_RST   = 8'h00;
    localparam logic [7:0]  EXT_BASE_RST   = 8'h00;
    localparam logic [7:0]  PRIO_STACK_RST = 8'h00;

    // Restart trap low bytes that exist; others are not implemented
    localparam logic [7:0]  TRAP_10        = 8'h10;
    localparam logic [7:0]  TRAP_18        = 8'h18;
    localparam logic [7:0]  TRAP_20        = 8'h20;
    localparam logic [7:0]  TRAP_28        = 8'h28;
    localparam logic [7:0]  TRAP_38        = 8'h38;

    localparam logic [1:0]  PRIO_MAX       = 2'h3;

    // Instruction class codes presented by the decoder on i_op
    localparam logic [3:0]  OP_NONE        = 4'h0;
    localparam logic [3:0]  OP_PRIO_SET    = 4'h1;
    localparam logic [3:0]  OP_PRIO_REST   = 4'h2;
    localparam logic [3:0]  OP_PRIO_SAVE   = 4'h3;
    localparam logic [3:0]  OP_PRIO_LOAD   = 4'h4;
    localparam logic [3:0]  OP_RETI        = 4'h5;
    localparam logic [3:0]  OP_WR_INT_BASE = 4'h6;
    localparam logic [3:0]  OP_WR_EXT_BASE = 4'h7;
    localparam logic [3:0]  OP_RD_INT_BASE = 4'h8;
    localparam logic [3:0]  OP_RD_EXT_BASE = 4'h9;
    localparam logic [3:0]  OP_LD_SP       = 4'ha;
    localparam logic [3:0]  OP_PAGE_ACCESS = 4'hb;
    localparam logic [3:0]  OP_BIT_TEST_HL = 4'hc;
    localparam logic [3:0]  OP_TRAP        = 4'hd;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_PUSH  = 4'b0010,
        ST_JUMP  = 4'b0100,
        ST_RPOP  = 4'b1000
    } seq_state_t;

endpackage

// *** design/prio_stack.sv ***
module prio_stack (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_push,
    input  wire logic [1:0] i_push_val,
    input  wire logic       i_rotate,
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_val,
    output logic [7:0]      o_value
);

    logic [7:0] next_value;

    assign next_value = i_load   ? i_load_val :
                        i_push   ? {o_value[5:0], i_push_val} :
                        i_rotate ? {o_value[1:0], o_value[7:2]} :
                        o_value;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_value <= prio_irq_pkg::PRIO_STACK_RST;
        else
            o_value <= next_value;
    end

endmodule

// *** design/priority_interrupt_unit.sv ***
// Summary of operation
// - Accept: push return address, then jump
// - Vector is base high byte, fixed low byte
// - Separate internal and external base registers
// - Traps at 10,18,20,28,38; 00,08,30 absent
// - Traps taken at any priority
// - Trap high byte from internal base
// - Page register untouched by interrupt entry
// - Accept when higher priority, at instruction end
// - Eight-bit priority register, four-deep stack
// - Accept shifts left, loads request priority, except at end of priority load or return
// - Priority-set shifts left, loads operand
// - Priority-restore rotates right two bits
// - Save/load priority; return reloads priority register from operand
// - Level gates lower or equal priorities
// - Two edge-sensitive external request inputs
// - External pin levels readable on port
// - After privileged instruction, defer acceptance
// - Stack pointer loads are privileged
// - Priority-set and restore are privileged
// - Page access and bit test privileged
module priority_interrupt_unit #(
    parameter int NUM_INT = 4
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_instr_done,
    input  wire logic [3:0]         i_op,
    input  wire logic [7:0]         i_op_data,
    input  wire logic [NUM_INT-1:0] i_int_req,
    input  wire logic [2*NUM_INT-1:0] i_int_prio,
    input  wire logic [8*NUM_INT-1:0] i_int_low,
    input  wire logic [1:0]         i_ext_pin,
    input  wire logic [1:0]         i_ext_rising,
    input  wire logic [1:0]         i_ext_prio0,
    input  wire logic [1:0]         i_ext_prio1,
    input  wire logic [7:0]         i_ext_low0,
    input  wire logic [7:0]         i_ext_low1,
    input  wire logic [15:0]        i_return_addr,
    input  wire logic               i_mem_ack,
    output logic                    o_take,
    output logic                    o_push_req,
    output logic [15:0]             o_push_data,
    output logic                    o_jump,
    output logic [15:0]             o_jump_addr,
    output logic [NUM_INT-1:0]      o_int_ack,
    output logic [7:0]              o_rd_data,
    output logic [7:0]              o_prio_stack,
    output logic [1:0]              o_ext_level
);

    initial
    begin
        if (NUM_INT < 1 || NUM_INT > 16)
            $error("NUM_INT out of range");
    end

    logic [7:0]  internal_vector_base;
    logic [7:0]  external_vector_base;
    logic        defer;
    logic [15:0] vec_addr;
    logic [1:0]  vec_prio;
    logic        vec_ext;
    logic [1:0]  vec_ext_sel;
    logic [NUM_INT-1:0] vec_int_sel;
    prio_irq_pkg::seq_state_t state;
    prio_irq_pkg::seq_state_t next_state;

    logic [1:0]  ext_pend;
    logic [1:0]  ext_clear;
    logic [1:0]  cur_prio;

    // Privilege decoding
    logic        op_priv;
    logic        trap_ok;
    logic        trap_now;
    logic        best_valid;
    logic [1:0]  best_prio;
    logic [7:0]  best_low;
    logic        best_ext;
    logic [1:0]  best_ext_sel;
    logic [NUM_INT-1:0] best_int_sel;
    logic        accept;
    logic        push_prio;
    logic [1:0]  push_val;
    logic        rot_prio;
    logic        load_prio;

    function automatic logic is_trap_code(input logic [7:0] code);
        is_trap_code = (code == prio_irq_pkg::TRAP_10) || (code == prio_irq_pkg::TRAP_18) ||
                       (code == prio_irq_pkg::TRAP_20) || (code == prio_irq_pkg::TRAP_28) ||
                       (code == prio_irq_pkg::TRAP_38);
    endfunction

    assign cur_prio = o_prio_stack[1:0];

    assign op_priv = (i_op == prio_irq_pkg::OP_LD_SP)       ||
                     (i_op == prio_irq_pkg::OP_PRIO_SET)    ||
                     (i_op == prio_irq_pkg::OP_PRIO_REST)   ||
                     (i_op == prio_irq_pkg::OP_PAGE_ACCESS) ||
                     (i_op == prio_irq_pkg::OP_BIT_TEST_HL);

    // Codes 00, 08, 30 and any other byte do nothing
    assign trap_ok  = is_trap_code(i_op_data);
    assign trap_now = i_instr_done && (i_op == prio_irq_pkg::OP_TRAP) && trap_ok
                      && (state == prio_irq_pkg::ST_IDLE);

    // Highest-priority pending source; external lines first on ties
    always_comb
    begin
        best_valid   = 1'b0;
        best_prio    = 2'h0;
        best_low     = 8'h00;
        best_ext     = 1'b0;
        best_ext_sel = 2'h0;
        best_int_sel = '0;
        for (int k = 0; k < NUM_INT; k++)
        begin
            if (i_int_req[k] && (i_int_prio[2*k +: 2] > best_prio))
            begin
                best_valid   = 1'b1;
                best_prio    = i_int_prio[2*k +: 2];
                best_low     = i_int_low[8*k +: 8];
                best_int_sel = NUM_INT'(1) << k;
            end
        end
        if (ext_pend[1] && (i_ext_prio1 >= best_prio) && (i_ext_prio1 != 2'h0))
        begin
            best_valid   = 1'b1;
            best_prio    = i_ext_prio1;
            best_low     = i_ext_low1;
            best_ext     = 1'b1;
            best_ext_sel = 2'h2;
            best_int_sel = '0;
        end
        if (ext_pend[0] && (i_ext_prio0 >= best_prio) && (i_ext_prio0 != 2'h0))
        begin
            best_valid   = 1'b1;
            best_prio    = i_ext_prio0;
            best_low     = i_ext_low0;
            best_ext     = 1'b1;
            best_ext_sel = 2'h1;
            best_int_sel = '0;
        end
    end

    // Strictly greater than current level, at end of unprivileged instruction
    assign accept = i_instr_done && !defer && !op_priv && best_valid
                    && (best_prio > cur_prio) && !trap_now
                    && (i_op != prio_irq_pkg::OP_TRAP)
                    && (state == prio_irq_pkg::ST_IDLE);

    assign o_take = accept | trap_now;

    assign push_prio = accept ||
                       (i_instr_done && (i_op == prio_irq_pkg::OP_PRIO_SET));
    assign push_val  = accept ? best_prio : i_op_data[1:0];
    assign rot_prio  = i_instr_done && (i_op == prio_irq_pkg::OP_PRIO_REST);
    assign load_prio = i_instr_done && ((i_op == prio_irq_pkg::OP_PRIO_LOAD) ||
                       (i_op == prio_irq_pkg::OP_RETI));

    prio_stack u_prio_stack (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_push     (push_prio),
        .i_push_val (push_val),
        .i_rotate   (rot_prio),
        .i_load     (load_prio),
        .i_load_val (i_op_data),
        .o_value    (o_prio_stack)
    );

    assign ext_clear = (accept && best_ext) ? best_ext_sel : 2'h0;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ext
            ext_req_edge u_edge (
                .i_clk     (i_clk),
                .i_rst_b   (i_rst_b),
                .i_pin     (i_ext_pin[g]),
                .i_rising  (i_ext_rising[g]),
                .i_clear   (ext_clear[g]),
                .o_level   (o_ext_level[g]),
                .o_pending (ext_pend[g])
            );
        end
    endgenerate

    // Entry sequence: push return address, wait ack, then jump
    always_comb
    begin
        next_state = state;
        unique case (state)
            prio_irq_pkg::ST_IDLE:
                if (o_take)
                    next_state = prio_irq_pkg::ST_PUSH;
            prio_irq_pkg::ST_PUSH:
                if (i_mem_ack)
                    next_state = prio_irq_pkg::ST_JUMP;
            prio_irq_pkg::ST_JUMP:
                next_state = prio_irq_pkg::ST_IDLE;
            prio_irq_pkg::ST_RPOP:
                next_state = prio_irq_pkg::ST_IDLE;
        endcase
    end

    assign o_push_req = (state == prio_irq_pkg::ST_PUSH);
    assign o_jump     = (state == prio_irq_pkg::ST_JUMP);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state                <= prio_irq_pkg::ST_IDLE;
            internal_vector_base <= prio_irq_pkg::INT_BASE_RST;
            external_vector_base <= prio_irq_pkg::EXT_BASE_RST;
            defer                <= 1'b0;
            vec_addr             <= 16'h0000;
            vec_prio             <= 2'h0;
            vec_ext              <= 1'b0;
            vec_ext_sel          <= 2'h0;
            vec_int_sel          <= '0;
            o_push_data          <= 16'h0000;
            o_jump_addr          <= 16'h0000;
            o_int_ack            <= '0;
            o_rd_data            <= 8'h00;
        end
        else
        begin
            state     <= next_state;
            o_int_ack <= '0;
            if (i_instr_done)
                defer <= op_priv;
            if (i_instr_done && i_op == prio_irq_pkg::OP_WR_INT_BASE)
                internal_vector_base <= i_op_data;
            if (i_instr_done && i_op == prio_irq_pkg::OP_WR_EXT_BASE)
                external_vector_base <= i_op_data;
            if (i_op == prio_irq_pkg::OP_RD_INT_BASE)
                o_rd_data <= internal_vector_base;
            else if (i_op == prio_irq_pkg::OP_RD_EXT_BASE)
                o_rd_data <= external_vector_base;
            else if (i_op == prio_irq_pkg::OP_PRIO_SAVE)
                o_rd_data <= o_prio_stack;
            if (trap_now)
            begin
                vec_addr <= {internal_vector_base, i_op_data};
                vec_ext  <= 1'b0;
            end
            else if (accept)
            begin
                vec_addr    <= {best_ext ? external_vector_base
                                         : internal_vector_base, best_low};
                vec_prio    <= best_prio;
                vec_ext     <= best_ext;
                vec_ext_sel <= best_ext_sel;
                vec_int_sel <= best_int_sel;
                o_int_ack   <= best_int_sel;
            end
            if (o_take)
                o_push_data <= i_return_addr;
            // Page register is not an input or output here, so entry leaves it
            if (state == prio_irq_pkg::ST_PUSH && i_mem_ack)
                o_jump_addr <= vec_addr;
        end
    end

endmodule

// *** test/irq_far_side.sv ***
module irq_far_side (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_push_req,
    input  wire logic [3:0] i_delay,
    input  wire logic [1:0] i_dev_attn,
    output logic            o_mem_ack,
    output logic            o_shared_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_cnt;
    // Two devices share one line; simultaneous requests give one edge
    assign o_shared_line = |i_dev_attn;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wait_cnt <= 4'h0;
            o_mem_ack <= 1'b0;
        end
        else
        begin
            o_mem_ack <= i_push_req && !o_mem_ack && wait_cnt == i_delay;
            wait_cnt <= (i_push_req && !o_mem_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// *** test/priority_interrupt_unit_props.sv ***
module priority_interrupt_unit_chk #(
    parameter int NUM_INT = 4
) (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_instr_done,
    input wire logic [3:0]  i_op,
    input wire logic [7:0]  i_op_data,
    input wire logic [15:0] i_return_addr,
    input wire logic        i_mem_ack,
    input wire logic        o_take,
    input wire logic        o_push_req,
    input wire logic [15:0] o_push_data,
    input wire logic        o_jump,
    input wire logic [7:0]  o_prio_stack
);
    logic priv_now;
    logic is_trap;
    logic trap_ok;
    logic last_priv;
    assign priv_now = i_op inside {prio_irq_pkg::OP_LD_SP, prio_irq_pkg::OP_PAGE_ACCESS,
        prio_irq_pkg::OP_BIT_TEST_HL, prio_irq_pkg::OP_PRIO_SET, prio_irq_pkg::OP_PRIO_REST};
    assign is_trap = i_op == prio_irq_pkg::OP_TRAP;
    assign trap_ok = i_op_data inside {8'h10, 8'h18, 8'h20, 8'h28, 8'h38};
    // A privileged finish still blocks the next instruction end
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            last_priv <= 1'b0;
        else if (i_instr_done)
            last_priv <= priv_now;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    chk_take_push:
        assert property (o_take |=> o_push_req && o_push_data == $past(i_return_addr))
        else $error("return address push missing");
    chk_ack_jump:
        assert property (o_push_req && i_mem_ack |=> o_jump ##1 !o_jump)
        else $error("jump not one cycle after ack");
    chk_take_at_end:
        assert property (o_take |-> i_instr_done)
        else $error("take outside instruction end");
    chk_take_shift:
        assert property (o_take && !is_trap |=> o_prio_stack[7:2] == $past(o_prio_stack[5:0]))
        else $error("priority not shifted on take");
    chk_trap_taken:
        assert property (i_instr_done && is_trap && trap_ok && !o_push_req && !o_jump |-> o_take)
        else $error("trap not taken");
    chk_trap_absent:
        assert property (i_instr_done && is_trap && !trap_ok |-> !o_take)
        else $error("absent trap taken");
    chk_level_gate:
        assert property (o_prio_stack[1:0] == prio_irq_pkg::PRIO_MAX && !is_trap |-> !o_take)
        else $error("take at top priority");
    chk_priv_defer:
        assert property (i_instr_done && !is_trap && (priv_now || last_priv) |-> !o_take)
        else $error("take after privileged instruction");
    chk_set_push:
        assert property (i_instr_done && i_op == prio_irq_pkg::OP_PRIO_SET |=>
            o_prio_stack == {$past(o_prio_stack[5:0]), $past(i_op_data[1:0])})
        else $error("priority set wrong");
    chk_rest_rotate:
        assert property (i_instr_done && i_op == prio_irq_pkg::OP_PRIO_REST |=>
            o_prio_stack == {$past(o_prio_stack[1:0]), $past(o_prio_stack[7:2])})
        else $error("priority restore wrong");

    cover property (o_take && is_trap);
    cover property (o_jump);
    cover property (i_instr_done && last_priv);
endmodule

bind priority_interrupt_unit priority_interrupt_unit_chk #(.NUM_INT(NUM_INT)) chk_u (.*);

// *** test/test_priority_interrupt_unit.sv ***
module test_priority_interrupt_unit;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_instr_done = 1'b0;
    logic [3:0]  i_op = 4'h0;
    logic [7:0]  i_op_data = 8'h00;
    logic [3:0]  i_int_req = 4'h0;
    logic [7:0]  i_int_prio = 8'h00;
    logic [31:0] i_int_low = 32'h70605040;
    logic [1:0]  i_ext_rising = 2'h1;
    logic [1:0]  i_ext_prio0 = 2'h3;
    logic [1:0]  i_ext_prio1 = 2'h2;
    logic [15:0] i_return_addr = 16'h1234;
    logic [3:0]  delay = 4'h0;
    logic [1:0]  attn = 2'h0;
    logic        pin1 = 1'b1;
    logic        line0, mem_ack, o_take, o_push_req, o_jump;
    logic [15:0] o_push_data, o_jump_addr, jaddr;
    logic [3:0]  ack_seen;
    logic [3:0]  o_int_ack;
    logic [7:0]  o_rd_data, o_prio_stack;
    logic [1:0]  o_ext_level;
    logic [7:0]  traps [5] = '{8'h10, 8'h18, 8'h20, 8'h28, 8'h38};
    logic [7:0]  bad [3] = '{8'h00, 8'h08, 8'h30};
    logic [3:0]  privs [5] = '{prio_irq_pkg::OP_LD_SP, prio_irq_pkg::OP_PAGE_ACCESS,
        prio_irq_pkg::OP_BIT_TEST_HL, prio_irq_pkg::OP_PRIO_SET, prio_irq_pkg::OP_PRIO_REST};
    int          err_total = 0;
    int          n_checks = 0;

    always #12.5 i_clk = ~i_clk;

    priority_interrupt_unit #(.NUM_INT(4)) dut_u (.i_ext_pin({pin1, line0}), .i_mem_ack(mem_ack),
        .i_ext_low0(8'h50), .i_ext_low1(8'h58), .*);
    irq_far_side far_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_push_req(o_push_req),
        .i_delay(delay), .i_dev_attn(attn), .o_mem_ack(mem_ack), .o_shared_line(line0));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Ends 2 ns after an edge so registered outputs have settled
    task automatic instr(input logic [3:0] op, input logic [7:0] d, input logic t);
        int n;
        @(posedge i_clk);
        i_instr_done <= 1'b1;
        i_op <= op;
        i_op_data <= d;
        #2;
        chk(o_take, t);
        @(posedge i_clk);
        i_instr_done <= 1'b0;
        #2;
        // Internal acknowledge stands only in the cycle after the take
        ack_seen = o_int_ack;
        n = 0;
        while (t && o_jump !== 1'b1 && n < 40)
        begin
            @(posedge i_clk);
            #2;
            n++;
        end
        jaddr = o_jump_addr;
    endtask

    task automatic req(input logic [3:0] r, input logic [1:0] p);
        @(posedge i_clk);
        i_int_req <= r;
        i_int_prio <= {6'h00, p};
    endtask

    initial
    begin
        #500000;
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        instr(prio_irq_pkg::OP_RD_INT_BASE, 8'h00, 0);
        chk(o_rd_data, prio_irq_pkg::INT_BASE_RST);
        chk(o_prio_stack, prio_irq_pkg::PRIO_STACK_RST);
        instr(prio_irq_pkg::OP_WR_INT_BASE, 8'h12, 0);
        instr(prio_irq_pkg::OP_WR_EXT_BASE, 8'h34, 0);
        instr(prio_irq_pkg::OP_RD_INT_BASE, 8'h00, 0);
        chk(o_rd_data, 8'h12);
        instr(prio_irq_pkg::OP_RD_EXT_BASE, 8'h00, 0);
        chk(o_rd_data, 8'h34);
        instr(prio_irq_pkg::OP_PRIO_SET, 8'h03, 0);
        chk(o_prio_stack, 8'h03);
        foreach (traps[i])
        begin
            delay <= 4'(i * 3);
            instr(prio_irq_pkg::OP_TRAP, traps[i], 1);
            chk(jaddr, {8'h12, traps[i]});
            instr(prio_irq_pkg::OP_PRIO_LOAD, 8'h03, 0);
        end
        foreach (bad[i])
            instr(prio_irq_pkg::OP_TRAP, bad[i], 0);
        instr(prio_irq_pkg::OP_PRIO_SET, 8'h01, 0);
        instr(prio_irq_pkg::OP_PRIO_SET, 8'h02, 0);
        chk(o_prio_stack, 8'h36);
        instr(prio_irq_pkg::OP_PRIO_REST, 8'h00, 0);
        chk(o_prio_stack, 8'h8d);
        instr(prio_irq_pkg::OP_PRIO_SAVE, 8'h00, 0);
        chk(o_rd_data, 8'h8d);
        instr(prio_irq_pkg::OP_RETI, 8'h00, 0);
        chk(o_prio_stack, 8'h00);
        for (int p = 0; p < 4; p++)
            for (int q = 1; q < 4; q++)
            begin
                instr(prio_irq_pkg::OP_PRIO_LOAD, 8'(p), 0);
                instr(prio_irq_pkg::OP_NONE, 8'h00, 0);
                req(4'h1, 2'(q));
                instr(prio_irq_pkg::OP_NONE, 8'h00, q > p);
                chk(o_prio_stack, (q > p) ? 16'(p * 4 + q) : 16'(p));
                chk(ack_seen, (q > p) ? 16'h0001 : 16'h0000);
                if (q > p)
                    chk(jaddr, 16'h1240);
                req(4'h0, 2'h0);
            end
        foreach (privs[i])
        begin
            instr(prio_irq_pkg::OP_PRIO_LOAD, 8'h00, 0);
            req(4'h1, 2'h1);
            instr(privs[i], 8'h00, 0);
            instr(prio_irq_pkg::OP_NONE, 8'h00, 0);
            instr(prio_irq_pkg::OP_NONE, 8'h00, 1);
            req(4'h0, 2'h0);
        end
        instr(prio_irq_pkg::OP_PRIO_LOAD, 8'h00, 0);
        instr(prio_irq_pkg::OP_NONE, 8'h00, 0);
        attn <= 2'b10;
        repeat (4) @(posedge i_clk);
        // Let the filtered level settle past the edge that loads it
        #2;
        chk(o_ext_level, 2'b11);
        instr(prio_irq_pkg::OP_NONE, 8'h00, 1);
        chk(jaddr, 16'h3450);
        chk(o_prio_stack, 8'h03);
        instr(prio_irq_pkg::OP_PRIO_LOAD, 8'h00, 0);
        attn <= 2'b00;
        repeat (4) @(posedge i_clk);
        instr(prio_irq_pkg::OP_NONE, 8'h00, 0);
        pin1 <= 1'b0;
        repeat (4) @(posedge i_clk);
        #2;
        chk(o_ext_level, 2'b00);
        instr(prio_irq_pkg::OP_NONE, 8'h00, 1);
        chk(jaddr, 16'h3458);
        conclude();
    end
endmodule
